// ===== tb/asp_far_end.sv
// far-side model: external hf clock source and frame sync line
`timescale 1ns/1ps
`default_nettype none
module asp_far_end (
  input  wire  logic                                       run,
  input  wire  logic                                       flagLevel,
  input  wire  asp_pkg::asp_pin_drv_t [asp_pkg::NPINS-1:0] pinDrv,
  output logic [asp_pkg::NPINS-1:0]                        pinIn
);
  import asp_pkg::*;
  logic hfClk = 1'b0;
  // source stands still between bursts, toggles land on sys_clk falling edges
  always begin
    #200;
    if (run) hfClk = ~hfClk;
  end
  // a driving device wins the wire, else the far side sets the level
  always_comb begin
    pinIn[0] = pinDrv[0].oe ? pinDrv[0].out : hfClk;
    pinIn[1] = pinDrv[1].oe ? pinDrv[1].out : hfClk;
    pinIn[2] = pinDrv[2].oe ? pinDrv[2].out : flagLevel;
  end
endmodule
`default_nettype wire

// ===== tb/asp_pin_mux_tb.sv
// self-checking bench for the audio serial pin-function block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) note(32'(g), 32'(e))
module asp_pin_mux_tb;
  import asp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  asp_apb_req_t apbReq = '0;
  asp_apb_rsp_t apbRsp;
  logic [NPINS-1:0] pinIn;
  asp_pin_drv_t [NPINS-1:0] pinDrv;
  logic fsFromRx = 1'b0, bufEn = 1'b0, frameStb = 1'b0, slotStb = 1'b0;
  logic fsToRx, rxTick, txTick, rxFromPin, txFromPin;
  logic run = 1'b0, flagLvl = 1'b0, cntOn = 1'b0, err;
  logic [1:0] prv;
  logic [31:0] rd, obsVal, expQ[$];
  logic [7:0] lfsr = 8'h50;
  int mismatches = 0, check_count = 0, rxCnt = 0, txCnt = 0, tg = 0;
  event obsEv;
  wire logic [2:0] oeV = {pinDrv[2].oe, pinDrv[1].oe, pinDrv[0].oe};
  wire logic [2:0] outV = {pinDrv[2].out, pinDrv[1].out, pinDrv[0].out};

  always #25 sys_clk = ~sys_clk;

  asp_pin_mux i_dut (.sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .pinIn(pinIn), .pinDrv(pinDrv), .rxFrameSyncFromRx(fsFromRx), .txExtBufEnable(bufEn),
    .frameStrobe(frameStb), .slotStrobe(slotStb), .rxFrameSyncToRx(fsToRx),
    .rxClkTick(rxTick), .txClkTick(txTick), .rxClkFromPin(rxFromPin),
    .txClkFromPin(txFromPin));
  asp_far_end i_far (.run(run), .flagLevel(flagLvl), .pinDrv(pinDrv), .pinIn(pinIn));

  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic note(input logic [31:0] g, input logic [31:0] e);
    expQ.push_back(e);
    obsVal = g;
    ->obsEv;
    #1;
  endtask

  // watcher: oldest expectation against the observed value
  always @(obsEv) begin
    check_count++;
    if (obsVal !== expQ[0]) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, obsVal, expQ[0]);
    end
    void'(expQ.pop_front());
  end

  // tick and toggle counters over a window; falling edge sees settled outputs
  always @(negedge sys_clk) begin
    prv <= outV[1:0];
    if (cntOn) begin
      rxCnt += int'(rxTick);
      txCnt += int'(txTick);
      tg += int'(outV[0] != prv[0]) + int'(outV[1] != prv[1]);
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    if (n >= 16) mismatches++;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    #1;
  endtask

  task automatic pulse(input logic net);
    @(posedge sys_clk);
    if (net) slotStb <= 1'b1;
    else frameStb <= 1'b1;
    @(posedge sys_clk);
    slotStb <= 1'b0;
    frameStb <= 1'b0;
    cyc(2);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog sized well past the ~210 cycles the sequence needs
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    `CHK({oeV, rxTick, txTick, rxFromPin, txFromPin}, 7'h0c);
    apb(0, PIN_CFG_OFS, 0);
    `CHK(rd, PIN_CFG_RST);
    apb(1, 8'h40, 32'hffff_ffff);
    apb(0, 8'h40, 0);
    `CHK({err, rd[30:0]}, 32'h8000_0000);
    apb(1, PIN_CFG_OFS, 32'h3f);
    `CHK({rxFromPin, txFromPin}, 2'b11);
    cntOn <= 1'b1;
    run <= 1'b1;
    cyc(80);
    run <= 1'b0;
    cyc(8);
    cntOn <= 1'b0;
    cyc(1);
    `CHK(rxCnt, 10);
    `CHK(txCnt, 10);
    lfsr = next_rand(lfsr);
    apb(1, SER_CFG_OFS, {22'h0, lfsr[1:0], 8'h03});
    cyc(4);
    rxCnt = 0;
    tg = 0;
    cntOn <= 1'b1;
    cyc(8 * (int'(lfsr[1:0]) + 1));
    cntOn <= 1'b0;
    cyc(1);
    `CHK({oeV[1:0], rxFromPin, txFromPin}, 4'hc);
    `CHK(tg, 16);
    `CHK(rxCnt, 8 * (int'(lfsr[1:0]) + 1));
    apb(1, PIN_CFG_OFS, 32'h30);
    apb(1, SER_CFG_OFS, 32'h10);
    fsFromRx <= 1'b1;
    cyc(2);
    `CHK({oeV[2], outV[2]}, 2'b11);
    fsFromRx <= 1'b0;
    flagLvl <= 1'b1;
    apb(1, SER_CFG_OFS, 32'h00);
    cyc(4);
    `CHK({oeV[2], fsToRx}, 2'b01);
    apb(1, SER_CFG_OFS, 32'h1c);
    bufEn <= 1'b1;
    cyc(2);
    `CHK({oeV[2], outV[2]}, 2'b11);
    bufEn <= 1'b0;
    cyc(2);
    `CHK(outV[2], 0);
    apb(1, SER_CFG_OFS, 32'h14);
    apb(1, FLAG_OFS, 1);
    `CHK(outV[2], 0);
    pulse(0);
    `CHK({oeV[2], outV[2]}, 2'b11);
    apb(1, SER_CFG_OFS, 32'h34);
    apb(1, FLAG_OFS, 0);
    pulse(0);
    `CHK(outV[2], 1);
    pulse(1);
    `CHK(outV[2], 0);
    apb(1, SER_CFG_OFS, 32'h04);
    cyc(3);
    pulse(0);
    apb(0, FLAG_OFS, 0);
    `CHK({oeV[2], rd[1]}, 2'b01);
    lfsr = next_rand(lfsr);
    apb(1, PIN_CFG_OFS, 32'h2a);
    apb(1, GPIO_OUT_OFS, {29'h0, lfsr[2:0]});
    `CHK({outV, oeV}, {lfsr[2:0], 3'h7});
    apb(1, PIN_CFG_OFS, 32'h15);
    cyc(3);
    apb(0, GPIO_IN_OFS, 0);
    `CHK(rd, 32'h4);
    apb(1, PIN_CFG_OFS, 32'h0);
    cyc(3);
    apb(0, GPIO_IN_OFS, 0);
    `CHK({rd[2:0], oeV}, 6'h00);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== verilog/asp_pin_mux.sv
// pin-function logic for the receiver/transmitter hf clock and receiver frame sync pins
`timescale 1ns/1ps
`default_nettype none

module asp_pin_mux #(
  parameter int DIV_W = asp_pkg::DIV_W_DEF
) (
  input  wire  logic                                 sys_clk,
  input  wire  logic                                 rst,
  input  wire  asp_pkg::asp_apb_req_t                apbReq,
  output var   asp_pkg::asp_apb_rsp_t                apbRsp,
  input  wire  logic [asp_pkg::NPINS-1:0]            pinIn,
  output var   asp_pkg::asp_pin_drv_t [asp_pkg::NPINS-1:0] pinDrv,
  input  wire  logic                                 rxFrameSyncFromRx,
  input  wire  logic                                 txExtBufEnable,
  input  wire  logic                                 frameStrobe,
  input  wire  logic                                 slotStrobe,
  output logic                                       rxFrameSyncToRx,
  output logic                                       rxClkTick,
  output logic                                       txClkTick,
  output logic                                       rxClkFromPin,
  output logic                                       txClkFromPin
);
  import asp_pkg::*;

  if (DIV_W < 1 || DIV_W > 32 - SER_DIV_LSB) begin : g_bad_div
    $error("DIV_W must lie between 1 and 24");
  end

  typedef struct packed {
    logic [2*NPINS-1:0]   pinCfg;
    logic [SER_CTL_W-1:0] ctl;
    logic [DIV_W-1:0]     div;
    logic                 of1;
    logic [NPINS-1:0]     gpioOut;
    logic [NPINS-1:0]     syncA;
    logic [NPINS-1:0]     syncB;
    logic [NPINS-1:0]     prevB;
    logic                 of1Pin;
    logic                 if1;
    logic [DIV_W-1:0]     hfCnt;
    logic                 hfClk;
    logic [31:0]          prdata;
  } asp_state_t;

  localparam asp_state_t STATE_RST = '{
    pinCfg:  PIN_CFG_RST,
    ctl:     SER_CTL_RST,
    div:     '0,
    of1:     1'b0,
    gpioOut: GPIO_OUT_RST,
    syncA:   '0,
    syncB:   '0,
    prevB:   '0,
    of1Pin:  1'b0,
    if1:     1'b0,
    hfCnt:   '0,
    hfClk:   1'b0,
    prdata:  32'h0000_0000
  };

  asp_state_t s_q;
  asp_state_t s_d;

  function automatic asp_pin_mode_t pinMode(input logic [2*NPINS-1:0] cfg, input int idx);
    pinMode = asp_pin_mode_t'(cfg[2*idx +: 2]);
  endfunction

  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = (a == PIN_CFG_OFS) || (a == SER_CFG_OFS) || (a == FLAG_OFS) ||
                (a == GPIO_OUT_OFS) || (a == GPIO_IN_OFS);
  endfunction

  // decoded configuration
  logic          syn;
  logic          tx_ext_buffer_enable_select;
  logic          rx_frame_sync_direction;
  logic          netMode;
  logic          fsSerial;
  logic          flagMode;
  logic          flagOut;
  logic          flagIn;
  logic          alignStrobe;
  logic [NPINS-1:0] inUse;
  logic [NPINS-1:0] gpioIn;
  logic          apbSetup;
  logic          apbWrite;

  assign syn      = s_q.ctl[SER_SYN_BIT];
  assign tx_ext_buffer_enable_select     = s_q.ctl[SER_TX_EXT_BUFFER_ENABLE_SELECT_BIT];
  assign rx_frame_sync_direction     = s_q.ctl[SER_RX_FRAME_SYNC_DIRECTION_BIT];
  assign netMode  = s_q.ctl[SER_NET_BIT];
  assign fsSerial = pinMode(s_q.pinCfg, PIN_RXFS) == PM_SERIAL;
  assign flagMode = fsSerial && syn && !tx_ext_buffer_enable_select;
  assign flagOut  = flagMode && rx_frame_sync_direction;
  assign flagIn   = flagMode && !rx_frame_sync_direction;
  // flag timing follows the frame in normal mode and the slot in network mode
  assign alignStrobe = netMode ? slotStrobe : frameStrobe;
  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;

  // which pins are really listening; a disconnected pin is never looked at
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      inUse[i] = pinMode(s_q.pinCfg, i) == PM_GPIO_IN;
    end
    inUse[PIN_RXHF] = inUse[PIN_RXHF] || (pinMode(s_q.pinCfg, PIN_RXHF) == PM_SERIAL &&
                      !s_q.ctl[SER_RXHF_OUT_BIT]);
    inUse[PIN_TXHF] = inUse[PIN_TXHF] || (pinMode(s_q.pinCfg, PIN_TXHF) == PM_SERIAL &&
                      !s_q.ctl[SER_TXHF_OUT_BIT]);
    inUse[PIN_RXFS] = inUse[PIN_RXFS] || (fsSerial && !rx_frame_sync_direction);
    for (int i = 0; i < NPINS; i++) begin
      gpioIn[i] = (pinMode(s_q.pinCfg, i) == PM_GPIO_IN) && s_q.syncB[i];
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    // two-stage synchronisers; only syncB feeds logic
    s_d.syncA = pinIn;
    s_d.syncB = s_q.syncA;
    s_d.prevB = s_q.syncB & inUse;
    // hf clock divider, half period is div+1 core cycles
    if (s_q.hfCnt == s_q.div) begin
      s_d.hfCnt = '0;
      s_d.hfClk = ~s_q.hfClk;
    end else begin
      s_d.hfCnt = s_q.hfCnt + DIV_W'(1);
    end
    if (alignStrobe) begin
      s_d.of1Pin = s_q.of1;
      if (flagIn) begin
        s_d.if1 = s_q.syncB[PIN_RXFS];
      end
    end
    if (apbSetup) begin
      unique case (apbReq.paddr)
        PIN_CFG_OFS:  s_d.prdata = 32'(s_q.pinCfg);
        SER_CFG_OFS:  s_d.prdata = 32'(s_q.ctl) | (32'(s_q.div) << SER_DIV_LSB);
        FLAG_OFS:     s_d.prdata = 32'({s_q.if1, s_q.of1});
        GPIO_OUT_OFS: s_d.prdata = 32'(s_q.gpioOut);
        GPIO_IN_OFS:  s_d.prdata = 32'(gpioIn);
        default:      s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (apbWrite) begin
      unique case (apbReq.paddr)
        PIN_CFG_OFS: begin
          s_d.pinCfg = apbReq.pwdata[2*NPINS-1:0];
        end
        SER_CFG_OFS: begin
          s_d.ctl = apbReq.pwdata[SER_CTL_W-1:0];
          s_d.div = apbReq.pwdata[SER_DIV_LSB +: DIV_W];
        end
        FLAG_OFS: begin
          s_d.of1 = apbReq.pwdata[FLAG_OF1_BIT];
        end
        GPIO_OUT_OFS: begin
          s_d.gpioOut = apbReq.pwdata[NPINS-1:0];
        end
        default: begin
        end
      endcase
    end
    if (rst) begin
      s_d = STATE_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // apb answers in the access cycle itself; no wait states
  always_comb begin
    apbRsp.prdata  = s_q.prdata;
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbReq.psel && apbReq.penable && !addrKnown(apbReq.paddr);
  end

  // pin drivers
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pinDrv[i] = '{out: 1'b0, oe: 1'b0};
      unique case (pinMode(s_q.pinCfg, i))
        PM_GPIO_OUT: pinDrv[i] = '{out: s_q.gpioOut[i], oe: 1'b1};
        PM_SERIAL: begin
          if (i == PIN_RXHF && s_q.ctl[SER_RXHF_OUT_BIT]) begin
            pinDrv[i] = '{out: s_q.hfClk, oe: 1'b1};
          end else if (i == PIN_TXHF && s_q.ctl[SER_TXHF_OUT_BIT]) begin
            pinDrv[i] = '{out: s_q.hfClk, oe: 1'b1};
          end else if (i == PIN_RXFS && rx_frame_sync_direction) begin
            if (!syn) begin
              pinDrv[i] = '{out: rxFrameSyncFromRx, oe: 1'b1};
            end else if (!tx_ext_buffer_enable_select) begin
              pinDrv[i] = '{out: s_q.of1Pin, oe: 1'b1};
            end else begin
              pinDrv[i] = '{out: txExtBufEnable, oe: 1'b1};
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // clock source selection; the pin clock is seen as one tick per rising edge,
  // so a pin clock faster than half of sys_clk is not followed
  always_comb begin
    rxClkFromPin = pinMode(s_q.pinCfg, PIN_RXHF) == PM_SERIAL && !s_q.ctl[SER_RXHF_OUT_BIT];
    txClkFromPin = pinMode(s_q.pinCfg, PIN_TXHF) == PM_SERIAL && !s_q.ctl[SER_TXHF_OUT_BIT];
    rxClkTick    = rxClkFromPin ? (s_q.syncB[PIN_RXHF] && !s_q.prevB[PIN_RXHF]) : 1'b1;
    txClkTick    = txClkFromPin ? (s_q.syncB[PIN_TXHF] && !s_q.prevB[PIN_TXHF]) : 1'b1;
    rxFrameSyncToRx = fsSerial && !syn && !rx_frame_sync_direction && s_q.syncB[PIN_RXFS];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rx_hf_edge: assert property (rxClkFromPin && $rose(s_q.syncB[PIN_RXHF]) &&
      $past(rxClkFromPin) |-> rxClkTick)
    else $error("rx hf pin edge gave no tick");
  a_rx_hf_drive: assert property (pinMode(s_q.pinCfg, PIN_RXHF) == PM_SERIAL &&
      s_q.ctl[SER_RXHF_OUT_BIT] |-> pinDrv[PIN_RXHF].oe &&
      pinDrv[PIN_RXHF].out == s_q.hfClk)
    else $error("rx hf pin not driving hf clock");
  a_tx_hf_core: assert property (!txClkFromPin |-> txClkTick)
    else $error("tx core clock tick missing");
  // toggle is checked at the divider's own end count, so any divider value is covered
  a_tx_hf_toggle: assert property (pinMode(s_q.pinCfg, PIN_TXHF) == PM_SERIAL &&
      s_q.ctl[SER_TXHF_OUT_BIT] && s_q.hfCnt == s_q.div ##1
      (pinMode(s_q.pinCfg, PIN_TXHF) == PM_SERIAL && s_q.ctl[SER_TXHF_OUT_BIT]) |->
      pinDrv[PIN_TXHF].out != $past(pinDrv[PIN_TXHF].out))
    else $error("tx hf pin clock not toggling");
  a_rx_hf_toggle: assert property (pinMode(s_q.pinCfg, PIN_RXHF) == PM_SERIAL &&
      s_q.ctl[SER_RXHF_OUT_BIT] && s_q.hfCnt == s_q.div ##1
      (pinMode(s_q.pinCfg, PIN_RXHF) == PM_SERIAL && s_q.ctl[SER_RXHF_OUT_BIT]) |->
      pinDrv[PIN_RXHF].out != $past(pinDrv[PIN_RXHF].out))
    else $error("rx hf pin clock not toggling");
  a_tx_hf_drive: assert property (pinMode(s_q.pinCfg, PIN_TXHF) == PM_SERIAL &&
      s_q.ctl[SER_TXHF_OUT_BIT] |-> pinDrv[PIN_TXHF].oe &&
      pinDrv[PIN_TXHF].out == s_q.hfClk)
    else $error("tx hf pin not driving hf clock");
  a_rx_hf_core: assert property (!rxClkFromPin |-> rxClkTick)
    else $error("rx core clock tick missing");
  a_tx_hf_edge: assert property (txClkFromPin && $rose(s_q.syncB[PIN_TXHF]) &&
      $past(txClkFromPin) |-> txClkTick)
    else $error("tx hf pin edge gave no tick");
  a_gpio_in_read: assert property (pinMode(s_q.pinCfg, PIN_RXFS) == PM_GPIO_IN |->
      gpioIn[PIN_RXFS] == s_q.syncB[PIN_RXFS])
    else $error("gpio input level not readable");
  a_pin_cfg_write: assert property (apbWrite && apbReq.paddr == PIN_CFG_OFS |=>
      s_q.pinCfg == $past(apbReq.pwdata[2*NPINS-1:0]))
    else $error("pin configuration write lost");
  a_gpio_out_write: assert property (apbWrite && apbReq.paddr == GPIO_OUT_OFS |=>
      s_q.gpioOut == $past(apbReq.pwdata[NPINS-1:0]))
    else $error("gpio output write lost");
  a_gpio_out_pin: assert property (apbWrite && apbReq.paddr == GPIO_OUT_OFS &&
      pinMode(s_q.pinCfg, PIN_RXFS) == PM_GPIO_OUT && !(apbWrite &&
      apbReq.paddr == PIN_CFG_OFS) |=> pinDrv[PIN_RXFS].oe &&
      pinDrv[PIN_RXFS].out == $past(apbReq.pwdata[PIN_RXFS]))
    else $error("gpio output write did not reach pin");
  a_reset_disc: assert property (disable iff (1'b0) $past(rst) |->
      !pinDrv[0].oe && !pinDrv[1].oe && !pinDrv[2].oe && !rxClkFromPin)
    else $error("pin driven after reset");
  // reset itself is watched with the guard off, as the default guard hides it
  a_reset_regs: assert property (disable iff (1'b0) $past(rst) |->
      s_q.pinCfg == PIN_CFG_RST && s_q.ctl == SER_CTL_RST &&
      s_q.gpioOut == GPIO_OUT_RST)
    else $error("configuration not cleared by reset");
  a_reset_ticks: assert property (disable iff (1'b0) $past(rst) |->
      rxClkTick && txClkTick && !txClkFromPin && !rxFrameSyncToRx)
    else $error("clock source not core clock after reset");
  a_async_fs: assert property (fsSerial && !syn && !rx_frame_sync_direction |-> !pinDrv[PIN_RXFS].oe &&
      rxFrameSyncToRx == s_q.syncB[PIN_RXFS])
    else $error("frame sync input not passed to receiver");
  a_async_fs_out: assert property (fsSerial && !syn && rx_frame_sync_direction |-> pinDrv[PIN_RXFS].oe &&
      pinDrv[PIN_RXFS].out == rxFrameSyncFromRx)
    else $error("frame sync output not on pin");
  a_sync_no_fs: assert property (fsSerial && syn |-> !rxFrameSyncToRx)
    else $error("frame sync passed to receiver in sync mode");
  a_flag_out: assert property (flagOut && alignStrobe ##1 flagOut |->
      pinDrv[PIN_RXFS].out == $past(s_q.of1))
    else $error("output flag not updated at alignment");
  a_flag_hold: assert property (flagOut && !alignStrobe ##1 flagOut |->
      $stable(pinDrv[PIN_RXFS].out))
    else $error("output flag moved between alignments");
  a_buf_enable: assert property (fsSerial && syn && tx_ext_buffer_enable_select && rx_frame_sync_direction |->
      pinDrv[PIN_RXFS].oe && pinDrv[PIN_RXFS].out == txExtBufEnable)
    else $error("buffer enable not on frame sync pin");
  // buffer select with input direction has no use; the pin must stay released
  a_buf_in_quiet: assert property (fsSerial && syn && tx_ext_buffer_enable_select && !rx_frame_sync_direction |->
      !pinDrv[PIN_RXFS].oe)
    else $error("frame sync pin driven with no function");
  a_flag_dir: assert property (flagMode |-> pinDrv[PIN_RXFS].oe == rx_frame_sync_direction)
    else $error("flag direction wrong");
  a_flag_in_quiet: assert property (flagIn |-> !pinDrv[PIN_RXFS].oe &&
      !rxFrameSyncToRx)
    else $error("input flag pin driven");
  a_of1_write: assert property (apbWrite && apbReq.paddr == FLAG_OFS |=>
      s_q.of1 == $past(apbReq.pwdata[FLAG_OF1_BIT]))
    else $error("output flag write lost");
  a_flag_in: assert property (flagIn && alignStrobe |=>
      s_q.if1 == $past(s_q.syncB[PIN_RXFS]))
    else $error("input flag not sampled");
  a_flag_in_hold: assert property (!(flagIn && alignStrobe) |=>
      $stable(s_q.if1))
    else $error("input flag moved between alignments");
  a_disc_quiet: assert property (pinMode(s_q.pinCfg, PIN_RXFS) == PM_DISC |->
      !pinDrv[PIN_RXFS].oe && !gpioIn[PIN_RXFS] && !rxFrameSyncToRx)
    else $error("disconnected pin driven or read");
  a_disc_rx_hf: assert property (pinMode(s_q.pinCfg, PIN_RXHF) == PM_DISC |->
      !pinDrv[PIN_RXHF].oe && !gpioIn[PIN_RXHF] && !rxClkFromPin && rxClkTick)
    else $error("disconnected rx hf pin driven or read");
  a_disc_tx_hf: assert property (pinMode(s_q.pinCfg, PIN_TXHF) == PM_DISC |->
      !pinDrv[PIN_TXHF].oe && !gpioIn[PIN_TXHF] && !txClkFromPin && txClkTick)
    else $error("disconnected tx hf pin driven or read");

endmodule

`default_nettype wire

// ===== verilog/asp_pkg.sv
// shared constants and types for the audio serial pin-function block
package asp_pkg;

  // register byte offsets
  localparam logic [7:0] PIN_CFG_OFS  = 8'h00;
  localparam logic [7:0] SER_CFG_OFS  = 8'h04;
  localparam logic [7:0] FLAG_OFS     = 8'h08;
  localparam logic [7:0] GPIO_OUT_OFS = 8'h0c;
  localparam logic [7:0] GPIO_IN_OFS  = 8'h10;

  // pin indices
  localparam int NPINS    = 3;
  localparam int PIN_RXHF = 0;
  localparam int PIN_TXHF = 1;
  localparam int PIN_RXFS = 2;

  // serial configuration fields
  localparam int SER_RXHF_OUT_BIT = 0;
  localparam int SER_TXHF_OUT_BIT = 1;
  localparam int SER_SYN_BIT      = 2;
  localparam int SER_TX_EXT_BUFFER_ENABLE_SELECT_BIT     = 3;
  localparam int SER_RX_FRAME_SYNC_DIRECTION_BIT     = 4;
  localparam int SER_NET_BIT      = 5;
  localparam int SER_CTL_W        = 6;
  localparam int SER_DIV_LSB      = 8;
  localparam int DIV_W_DEF        = 8;

  // flag register fields
  localparam int FLAG_OF1_BIT = 0;
  localparam int FLAG_IF1_BIT = 1;

  // reset values
  localparam logic [2*NPINS-1:0] PIN_CFG_RST  = 6'h00;
  localparam logic [SER_CTL_W-1:0] SER_CTL_RST = 6'h00;
  localparam logic [NPINS-1:0]   GPIO_OUT_RST = 3'h0;

  typedef enum logic [1:0] {
    PM_DISC     = 2'h0,
    PM_GPIO_IN  = 2'h1,
    PM_GPIO_OUT = 2'h2,
    PM_SERIAL   = 2'h3
  } asp_pin_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asp_apb_rsp_t;

  typedef struct packed {
    logic out;
    logic oe;
  } asp_pin_drv_t;

endpackage
